// ===== logic/fma_pkg.sv
// Constants for the frame metadata appender: record layout, field gates,
// item select codes and the microsecond time base.
// Assumes an 8-bit pixel stream and a single 125 MHz processing clock.
// How it works
// - Snapshot acquisition settings into frame record
// - Lag and counter only in standard format
// - Latch microsecond timestamp at frame start
// - Sample line levels when exposure begins
// - Capture counter value when readout starts
// - Record analog and digital gain separately
// - Item enable state is read only
// - Mode active enables all items together
// - Record starts at final line's first pixel
// - ID, size, availability always present
// - Availability bitmask sits at pixels 8-15
// - Present field sets its availability bit, binning excepted
// - Absent fields removed, later fields shift
// - Bits one to five: exposure..test index
// - Bits six to eleven: lines..image size
// - Bits twelve to thirty-one as listed
// - Append record only while mode active
// - Only 8-bit standard format carries metadata
// - Fixed identifier in first four pixels
// - Availability bit zero always zero
package fma_pkg;

  // Record identity and full structure size in bytes
  localparam logic [31:0] REC_ID     = 32'hCD000002;
  localparam int          REC_BYTES  = 140;
  localparam int          NSEG       = 21;
  localparam logic [7:0]  REC_END    = 8'h8C;
  localparam logic [63:0] BINNING_1X = 64'h0000000000000011;

  // Segment start offsets in the full structure, last entry is the end
  localparam int SEG_START [NSEG+1] = '{0, 4, 8, 16, 24, 32, 40, 48, 56, 58, 60,
                                        64, 68, 70, 72, 76, 84, 92, 100, 116,
                                        132, 140};
  // Availability bit gating each segment, zero means always in the structure
  localparam int SEG_BIT [NSEG] = '{0, 0, 0, 1, 2, 6, 8, 8, 10, 10, 16, 15,
                                    11, 11, 11, 12, 0, 28, 29, 30, 31};

  // Availability bit positions
  localparam int AV_EXPO    = 1;
  localparam int AV_PRESET  = 2;
  localparam int AV_FFC     = 3;
  localparam int AV_LUT     = 4;
  localparam int AV_TIDX    = 5;
  localparam int AV_LINES   = 6;
  localparam int AV_IRIS    = 7;
  localparam int AV_GAIN    = 8;
  localparam int AV_BLACK   = 9;
  localparam int AV_OFFSET  = 10;
  localparam int AV_SIZE    = 11;
  localparam int AV_TSTAMP  = 12;
  localparam int AV_FRAMEID = 13;
  localparam int AV_BINNING = 14;
  localparam int AV_LAG     = 15;
  localparam int AV_COUNTER = 16;
  localparam int AV_TESTIMG = 28;
  localparam int AV_SERIAL  = 29;
  localparam int AV_LABEL   = 30;
  localparam int AV_PIXENC  = 31;

  // Metadata format select codes
  localparam logic FMT_STANDARD = 1'b0;
  // Pixel encoding bits-per-pixel field
  localparam int         ENC_BPP_LSB = 16;
  localparam logic [7:0] ENC_BPP_8   = 8'h08;

  // Item select codes
  localparam logic [3:0] ITEM_HSTART  = 4'h0;
  localparam logic [3:0] ITEM_VSTART  = 4'h1;
  localparam logic [3:0] ITEM_WIDTH   = 4'h2;
  localparam logic [3:0] ITEM_HEIGHT  = 4'h3;
  localparam logic [3:0] ITEM_PIXENC  = 4'h4;
  localparam logic [3:0] ITEM_EXPO    = 4'h5;
  localparam logic [3:0] ITEM_LAG     = 4'h6;
  localparam logic [3:0] ITEM_PRESET  = 4'h7;
  localparam logic [3:0] ITEM_TSTAMP  = 4'h8;
  localparam logic [3:0] ITEM_LINES   = 4'h9;
  localparam logic [3:0] ITEM_GAIN    = 4'hA;
  localparam logic [3:0] ITEM_COUNTER = 4'hB;
  localparam logic [3:0] ITEM_SERIAL  = 4'hC;
  localparam logic [3:0] ITEM_LABEL   = 4'hD;
  localparam logic [3:0] ITEM_TESTIMG = 4'hE;

  // Time base
  localparam int          CLK_PERIOD_NS = 8;
  localparam int          US_NS         = 1000;
  localparam int          CYC_PER_US    = US_NS / CLK_PERIOD_NS;
  localparam logic [6:0]  US_DIV_LAST   = 7'(CYC_PER_US - 1);

  // Output FIFO shape
  localparam int FIFO_W = 10;
  localparam int FIFO_D = 8;

endpackage : fma_pkg

// ===== logic/fma_fifo.sv
// Small flip-flop FIFO with valid/ready on both sides.
// Assumes one clock; the reader may stall indefinitely.
`timescale 1ns/100ps
module fma_fifo #(
  parameter int W = 10,
  parameter int D = 8
) (
  input  wire logic         clk_i,
  input  wire logic         rst_n_i,
  input  wire logic         in_valid_i,
  output logic              in_ready_o,
  input  wire logic [W-1:0] in_data_i,
  output logic              out_valid_o,
  input  wire logic         out_ready_i,
  output logic [W-1:0]      out_data_o
);
  localparam int AW = $clog2(D);

  logic [W-1:0] mem [D];
  logic [AW:0]  wr_ptr;
  logic [AW:0]  rd_ptr;
  wire          empty = (wr_ptr == rd_ptr);
  wire          full  = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
  wire          push  = in_valid_i && !full;
  wire          pop   = out_valid_o && out_ready_i;

  // Flags come straight from the pointers so back-pressure is exact
  assign in_ready_o  = !full;
  assign out_valid_o = !empty;
  assign out_data_o  = mem[rd_ptr[AW-1:0]];

  // Storage has no reset; only slots behind the write pointer are read
  always_ff @(posedge clk_i)
  begin
    if (push)
    begin
      mem[wr_ptr[AW-1:0]] <= in_data_i;
    end
  end

  // Pointers carry an extra wrap bit to tell full from empty
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end
    else
    begin
      if (push) wr_ptr <= wr_ptr + 1'b1;
      if (pop)  rd_ptr <= rd_ptr + 1'b1;
    end
  end
endmodule : fma_fifo

// ===== logic/fma_us_timer.sv
// Free-running microsecond time base derived from the processing clock.
// Assumes the clock rate set in the package; wraps only after 2^64 us.
`timescale 1ns/100ps
module fma_us_timer
  import fma_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  output logic [63:0]      us_count_o
);
  logic [6:0] div_cnt;
  wire        us_tick = (div_cnt == US_DIV_LAST);

  // Divider makes a one-cycle enable each microsecond, counter follows it
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      div_cnt    <= '0;
      us_count_o <= '0;
    end
    else
    begin
      div_cnt <= us_tick ? 7'h00 : div_cnt + 7'h01;
      if (us_tick) us_count_o <= us_count_o + 64'h1;
    end
  end
endmodule : fma_us_timer

// ===== logic/fma_appender.sv
// Frame metadata appender: passes the image stream through and appends a
// metadata record starting at the first pixel of an extra final line.
// Assumes acquisition logic on the same clock gives one-cycle event pulses,
// and that the image stream marks end of line and end of frame.
`timescale 1ns/100ps
module fma_appender
  import fma_pkg::*;
(
  input  wire logic         clk_i,
  input  wire logic         rst_n_i,
  // Control and selection
  input  wire logic         metadata_mode_active_i,
  input  wire logic         metadata_format_select_i,
  input  wire logic [3:0]   metadata_item_select_i,
  output logic              metadata_item_enable_state_o,
  // Acquisition events
  input  wire logic         frame_start_i,
  input  wire logic         exposure_start_i,
  input  wire logic         readout_start_i,
  // Live values
  input  wire logic [15:0]  horizontal_start_i,
  input  wire logic [15:0]  vertical_start_i,
  input  wire logic [15:0]  image_width_i,
  input  wire logic [15:0]  image_height_i,
  input  wire logic [31:0]  pixel_encoding_i,
  input  wire logic [31:0]  exposure_duration_i,
  input  wire logic [31:0]  exposure_lag_i,
  input  wire logic [7:0]   active_preset_set_i,
  input  wire logic [3:0]   io_line_levels_i,
  input  wire logic [31:0]  counter_value_at_clear_i,
  input  wire logic [15:0]  analog_gain_value_i,
  input  wire logic [15:0]  digital_gain_raw_i,
  input  wire logic [7:0]   test_image_choice_i,
  input  wire logic [127:0] unit_serial_text_i,
  input  wire logic [127:0] user_assigned_label_i,
  // Image stream in
  input  wire logic         pix_valid_i,
  output logic              pix_ready_o,
  input  wire logic [7:0]   pix_data_i,
  input  wire logic         pix_eol_i,
  input  wire logic         pix_eof_i,
  // Payload stream out
  output logic              out_valid_o,
  input  wire logic         out_ready_i,
  output logic [7:0]        out_data_o,
  output logic              out_eol_o,
  output logic              out_eof_o
);

  typedef enum logic [1:0] {ST_PASS, ST_REC, ST_PAD} fma_state_e;

  // Skip forward over every absent segment the pointer lands in
  function automatic logic [7:0] fma_skip(input logic [7:0] ptr, input logic [63:0] av);
    logic [7:0] np;
    np = ptr;
    for (int s = 0; s < NSEG; s++)
    begin
      if (SEG_BIT[s] != 0 && !av[SEG_BIT[s]] && np >= 8'(SEG_START[s])
          && np < 8'(SEG_START[s+1]))
      begin
        np = 8'(SEG_START[s+1]);
      end
    end
    return np;
  endfunction : fma_skip

  // Sum of the byte lengths of all segments kept in the record
  function automatic logic [31:0] fma_rec_len(input logic [63:0] av);
    logic [31:0] len;
    len = '0;
    for (int s = 0; s < NSEG; s++)
    begin
      if (SEG_BIT[s] == 0 || av[SEG_BIT[s]])
      begin
        len = len + 32'(SEG_START[s+1] - SEG_START[s]);
      end
    end
    return len;
  endfunction : fma_rec_len

  fma_state_e          state;
  logic [63:0]         us_count;
  logic                fifo_in_valid;
  logic                fifo_in_ready;
  logic [FIFO_W-1:0]   fifo_in_data;
  logic [FIFO_W-1:0]   fifo_out_data;

  // Per-frame captured values
  logic                md_frame;
  logic [63:0]         cap_ts;
  logic [15:0]         cap_hs;
  logic [15:0]         cap_vs;
  logic [15:0]         cap_w;
  logic [15:0]         cap_h;
  logic [31:0]         cap_enc;
  logic [31:0]         cap_exp;
  logic [31:0]         cap_lag;
  logic [7:0]          cap_preset;
  logic [15:0]         cap_ag;
  logic [15:0]         cap_dg;
  logic [7:0]          cap_ti;
  logic [127:0]        cap_sn;
  logic [127:0]        cap_ul;
  logic [3:0]          cap_lines;
  logic [31:0]         cap_cnt;
  logic [63:0]         cap_av;

  // Emission state
  logic [REC_BYTES*8-1:0] snap;
  logic [15:0]         emit_w;
  logic [7:0]          ptr;
  logic [15:0]         col;
  logic [3:0]          lines_s1;
  logic [3:0]          lines_s2;
  logic [3:0]          lines_s3;
  logic [3:0]          lines_ok;

  fma_us_timer u_timer (
    .clk_i      (clk_i),
    .rst_n_i    (rst_n_i),
    .us_count_o (us_count)
  );

  // Metadata is only carried for 8-bit encodings in the standard format
  wire std_fmt   = (metadata_format_select_i == FMT_STANDARD);
  wire enc_8bit  = (pixel_encoding_i[ENC_BPP_LSB +: 8] == ENC_BPP_8);
  wire md_on     = metadata_mode_active_i && std_fmt && enc_8bit;

  // Availability mask: one switch enables every item; bit zero stays clear
  wire [63:0] live_av = md_on ?
    ((64'h1 << AV_EXPO) | (64'h1 << AV_PRESET) | (64'h1 << AV_LINES)
     | (64'h1 << AV_GAIN) | (64'h1 << AV_OFFSET) | (64'h1 << AV_SIZE)
     | (64'h1 << AV_TSTAMP) | (std_fmt ? (64'h1 << AV_LAG) : 64'h0)
     | (std_fmt ? (64'h1 << AV_COUNTER) : 64'h0)
     | (64'h1 << AV_TESTIMG) | (64'h1 << AV_SERIAL) | (64'h1 << AV_LABEL)
     | (64'h1 << AV_PIXENC)) & ~64'h1 : 64'h0;

  // Item enable readback reflects availability only; there is no write path
  logic item_av;
  always_comb
  begin
    case (metadata_item_select_i)
      ITEM_HSTART, ITEM_VSTART: item_av = live_av[AV_OFFSET];
      ITEM_WIDTH, ITEM_HEIGHT:  item_av = live_av[AV_SIZE];
      ITEM_PIXENC:              item_av = live_av[AV_PIXENC];
      ITEM_EXPO:                item_av = live_av[AV_EXPO];
      ITEM_LAG:                 item_av = live_av[AV_LAG];
      ITEM_PRESET:              item_av = live_av[AV_PRESET];
      ITEM_TSTAMP:              item_av = live_av[AV_TSTAMP];
      ITEM_LINES:               item_av = live_av[AV_LINES];
      ITEM_GAIN:                item_av = live_av[AV_GAIN];
      ITEM_COUNTER:             item_av = live_av[AV_COUNTER];
      ITEM_SERIAL:              item_av = live_av[AV_SERIAL];
      ITEM_LABEL:               item_av = live_av[AV_LABEL];
      ITEM_TESTIMG:             item_av = live_av[AV_TESTIMG];
      default:                  item_av = 1'b0;
    endcase
  end

  // Full structure, highest byte first; fields are little endian
  wire [REC_BYTES*8-1:0] live_rec = {
    {32'h0, cap_enc},           // pixel encoding
    cap_ul,                     // user label
    cap_sn,                     // serial text
    {56'h0, cap_ti},            // test image choice
    BINNING_1X,                 // binning, kept in structure, bit stays clear
    cap_ts,                     // timestamp
    32'h0,                      // reserved
    cap_h,
    cap_w,
    cap_lag,
    cap_cnt,
    cap_vs,
    cap_hs,
    {48'h0, cap_dg},
    {48'h0, cap_ag},
    {60'h0, cap_lines},
    {56'h0, cap_preset},
    {32'h0, cap_exp},
    cap_av,
    fma_rec_len(cap_av),
    REC_ID
  };

  // Record byte selection and end-of-line bookkeeping
  wire [10:0] bit_base  = {ptr, 3'b000};
  wire [7:0]  rec_byte  = snap[bit_base +: 8];
  wire [7:0]  next_ptr  = fma_skip(ptr + 8'h01, snap[127:64]);
  wire        rec_done  = (next_ptr >= REC_END);
  wire        last_col  = ((col + 16'h0001) >= emit_w);
  wire        fifo_take = fifo_in_valid && fifo_in_ready;

  // Stream mux: image pass-through, record bytes, then zero padding
  always_comb
  begin
    case (state)
      ST_PASS:
      begin
        fifo_in_valid = pix_valid_i;
        fifo_in_data  = {pix_eof_i && !md_frame, pix_eol_i, pix_data_i};
        pix_ready_o   = fifo_in_ready;
      end
      ST_REC:
      begin
        fifo_in_valid = 1'b1;
        fifo_in_data  = {rec_done && last_col, last_col, rec_byte};
        pix_ready_o   = 1'b0;
      end
      ST_PAD:
      begin
        fifo_in_valid = 1'b1;
        fifo_in_data  = {last_col, last_col, 8'h00};
        pix_ready_o   = 1'b0;
      end
      default:
      begin
        fifo_in_valid = 1'b0;
        fifo_in_data  = '0;
        pix_ready_o   = 1'b0;
      end
    endcase
  end

  // Line levels are pins: three stages, a change counts once stages two and three agree
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      lines_s1 <= '0;
      lines_s2 <= '0;
      lines_s3 <= '0;
      lines_ok <= '0;
    end
    else
    begin
      lines_s1 <= io_line_levels_i;
      lines_s2 <= lines_s1;
      lines_s3 <= lines_s2;
      if (lines_s2 == lines_s3) lines_ok <= lines_s3;
    end
  end

  // Settings in effect for the acquisition are frozen at frame start
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      md_frame   <= 1'b0;
      cap_ts     <= '0;
      cap_hs     <= '0;
      cap_vs     <= '0;
      cap_w      <= '0;
      cap_h      <= '0;
      cap_enc    <= '0;
      cap_exp    <= '0;
      cap_lag    <= '0;
      cap_preset <= '0;
      cap_ag     <= '0;
      cap_dg     <= '0;
      cap_ti     <= '0;
      cap_sn     <= '0;
      cap_ul     <= '0;
      cap_av     <= '0;
    end
    else if (frame_start_i)
    begin
      md_frame   <= md_on;
      cap_ts     <= us_count;
      cap_hs     <= horizontal_start_i;
      cap_vs     <= vertical_start_i;
      cap_w      <= image_width_i;
      cap_h      <= image_height_i;
      cap_enc    <= pixel_encoding_i;
      cap_exp    <= exposure_duration_i;
      cap_lag    <= exposure_lag_i;
      cap_preset <= active_preset_set_i;
      cap_ag     <= analog_gain_value_i;
      cap_dg     <= digital_gain_raw_i;
      cap_ti     <= test_image_choice_i;
      cap_sn     <= unit_serial_text_i;
      cap_ul     <= user_assigned_label_i;
      cap_av     <= live_av;
    end
  end

  // Instant captures: lines at exposure start, counter at readout start
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      cap_lines <= '0;
      cap_cnt   <= '0;
    end
    else
    begin
      if (exposure_start_i) cap_lines <= lines_ok;
      if (readout_start_i)  cap_cnt   <= counter_value_at_clear_i;
    end
  end

  // Record is snapshotted at the image's end so later frames cannot disturb it
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      snap   <= '0;
      emit_w <= '0;
    end
    else if (state == ST_PASS && fifo_take && pix_eof_i && md_frame)
    begin
      snap   <= live_rec;
      emit_w <= cap_w;
    end
  end

  // Sequencer: pass image, emit record from a fresh line, pad out the line
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      state <= ST_PASS;
      ptr   <= '0;
      col   <= '0;
    end
    else
    begin
      case (state)
        ST_PASS:
        begin
          if (fifo_take && pix_eof_i && md_frame)
          begin
            state <= ST_REC;
            ptr   <= '0;
            col   <= '0;
          end
        end
        ST_REC:
        begin
          if (fifo_take)
          begin
            col <= last_col ? 16'h0000 : col + 16'h0001;
            ptr <= next_ptr;
            if (rec_done) state <= last_col ? ST_PASS : ST_PAD;
          end
        end
        ST_PAD:
        begin
          if (fifo_take)
          begin
            col <= last_col ? 16'h0000 : col + 16'h0001;
            if (last_col) state <= ST_PASS;
          end
        end
        default: state <= ST_PASS;
      endcase
    end
  end

  // Enable readback is a registered status bit
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i) metadata_item_enable_state_o <= 1'b0;
    else          metadata_item_enable_state_o <= item_av;
  end

  // Output FIFO absorbs host stalls; its ready holds the image source
  fma_fifo #(
    .W (FIFO_W),
    .D (FIFO_D)
  ) u_fifo (
    .clk_i       (clk_i),
    .rst_n_i     (rst_n_i),
    .in_valid_i  (fifo_in_valid),
    .in_ready_o  (fifo_in_ready),
    .in_data_i   (fifo_in_data),
    .out_valid_o (out_valid_o),
    .out_ready_i (out_ready_i),
    .out_data_o  (fifo_out_data)
  );

  assign out_data_o = fifo_out_data[7:0];
  assign out_eol_o  = fifo_out_data[8];
  assign out_eof_o  = fifo_out_data[9];

endmodule : fma_appender

// ===== tb/fma_appender_chk.sv
// Checker for the appender's stream handshakes and item enable state.
// Assumes one clock domain and sees only the top module's ports.
`timescale 1ns/100ps
module fma_appender_chk
  import fma_pkg::*;
(
  input wire logic        clk_i,
  input wire logic        rst_n_i,
  input wire logic        metadata_mode_active_i,
  input wire logic        metadata_format_select_i,
  input wire logic [3:0]  metadata_item_select_i,
  input wire logic        metadata_item_enable_state_o,
  input wire logic        frame_start_i,
  input wire logic [31:0] pixel_encoding_i,
  input wire logic        pix_valid_i,
  input wire logic        pix_ready_o,
  input wire logic        pix_eof_i,
  input wire logic        out_valid_o,
  input wire logic        out_ready_i,
  input wire logic [7:0]  out_data_o,
  input wire logic        out_eol_o,
  input wire logic        out_eof_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  logic md_frame;
  wire  md_ok = metadata_mode_active_i && (metadata_format_select_i == FMT_STANDARD)
                && (pixel_encoding_i[23:16] == ENC_BPP_8);
  wire  lag_item = (metadata_item_select_i == ITEM_LAG)
                   || (metadata_item_select_i == ITEM_COUNTER);

  // Frame carries a record only if decided at its start
  always_ff @(posedge clk_i or negedge rst_n_i)
    if (!rst_n_i)
      md_frame <= 1'b0;
    else if (frame_start_i)
      md_frame <= md_ok;

  sequence s_eof_taken;
    pix_valid_i && pix_ready_o && pix_eof_i && md_frame;
  endsequence
  sequence s_out_stalled;
    out_valid_o && !out_ready_i;
  endsequence

  a_rec_holds_input: assert property (s_eof_taken |=> !pix_ready_o [*8])
    else $error("input taken while record goes out");
  a_eof_with_eol: assert property (out_valid_o && out_eof_o |-> out_eol_o)
    else $error("frame end without line end");
  a_out_stall_hold: assert property (s_out_stalled |=> out_valid_o
    && $stable(out_data_o) && $stable(out_eol_o) && $stable(out_eof_o))
    else $error("output beat changed while stalled");
  a_fifo_answer_next: assert property (pix_valid_i && pix_ready_o && !out_valid_o
    |=> out_valid_o)
    else $error("taken pixel not offered next cycle");
  a_en_mode_off: assert property (!metadata_mode_active_i |=> !metadata_item_enable_state_o)
    else $error("item enabled with mode off");
  a_en_all_on: assert property (md_ok && metadata_item_select_i != 4'hF
    |=> metadata_item_enable_state_o)
    else $error("item not enabled with mode on");
  a_en_fmt_lag: assert property (metadata_format_select_i != FMT_STANDARD && lag_item
    |=> !metadata_item_enable_state_o)
    else $error("lag or counter enabled in other format");
  a_en_no_item: assert property (metadata_item_select_i == 4'hF
    |=> !metadata_item_enable_state_o)
    else $error("unselected item shown enabled");
endmodule : fma_appender_chk

bind fma_appender fma_appender_chk u_chk (.clk_i, .rst_n_i, .metadata_mode_active_i,
  .metadata_format_select_i, .metadata_item_select_i, .metadata_item_enable_state_o,
  .frame_start_i, .pixel_encoding_i, .pix_valid_i, .pix_ready_o, .pix_eof_i,
  .out_valid_o, .out_ready_i, .out_data_o, .out_eol_o, .out_eof_o);

// ===== tb/fma_host_rx.sv
// Host receiver model: takes payload beats in order into a queue.
// Assumes the appender's valid/ready output stream on the same clock.
`timescale 1ns/100ps
module fma_host_rx
(
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  input  wire logic       stall_i,
  input  wire logic       slow_i,
  input  wire logic       valid_i,
  input  wire logic [7:0] data_i,
  input  wire logic       eol_i,
  input  wire logic       eof_i,
  output logic            ready_o
);
  logic [9:0] rxq [$];
  logic       phase;

  // Ready moves just after an edge; slow mode takes every other cycle
  always_ff @(posedge clk_i or negedge rst_n_i)
    if (!rst_n_i)
    begin
      phase   <= 1'b0;
      ready_o <= 1'b0;
    end
    else
    begin
      phase   <= !phase;
      ready_o <= !stall_i && (!slow_i || phase);
      if (valid_i && ready_o)
        rxq.push_back({eof_i, eol_i, data_i});
    end
endmodule : fma_host_rx

// ===== tb/tb_top.sv
// Testbench: frames with and without a record, host stalls, enable state.
// Assumes the host model and the bound checker; inputs move at falling edges.
`timescale 1ns/100ps
module tb_top
  import fma_pkg::*;
;
  logic clk = 0, rst_n = 0, md = 0, fmt = 0, fs = 0, es = 0, rs = 0;
  logic pv = 0, peol = 0, peof = 0, stall = 0, slow = 0;
  logic [3:0] sel = 4'hF, lines = 4'hA;
  logic [7:0] pd = 8'h00, pre, tst;
  logic [15:0] hs, vs, ag, dg, wd = 16'h0004, ht = 16'h0002;
  logic [31:0] enc = 32'h01080001, exd, lag, cnt;
  logic [127:0] ser, lab;
  wire pr, ov, oel, oef, en, rdy;
  wire [7:0] od;
  int err_total = 0, checks = 0, cyc = 0, sent = 0, t0 = 0;
  int offs [14] = '{16, 24, 32, 40, 48, 56, 60, 64, 68, 84, 92, 100, 116, 132};
  logic [31:0] exps [14] = '{32'h1234, 32'h3, 32'hA, 32'h1E, 32'h100, 32'h00340012,
    32'h0BADF00D, 32'h56, 32'h00020004, 32'h11, 32'hFF, 32'h31304E53, 32'h4C424C31,
    32'h01080001};
  logic [5:0] ecase [3] = '{{2'b11, ITEM_LAG}, {2'b11, ITEM_COUNTER}, {2'b00, ITEM_HSTART}};

  fma_appender uut (.clk_i(clk), .rst_n_i(rst_n), .metadata_mode_active_i(md),
    .metadata_format_select_i(fmt), .metadata_item_select_i(sel),
    .metadata_item_enable_state_o(en), .frame_start_i(fs), .exposure_start_i(es),
    .readout_start_i(rs), .horizontal_start_i(hs), .vertical_start_i(vs),
    .image_width_i(wd), .image_height_i(ht), .pixel_encoding_i(enc),
    .exposure_duration_i(exd), .exposure_lag_i(lag), .active_preset_set_i(pre),
    .io_line_levels_i(lines), .counter_value_at_clear_i(cnt), .analog_gain_value_i(ag),
    .digital_gain_raw_i(dg), .test_image_choice_i(tst), .unit_serial_text_i(ser),
    .user_assigned_label_i(lab), .pix_valid_i(pv), .pix_ready_o(pr), .pix_data_i(pd),
    .pix_eol_i(peol), .pix_eof_i(peof), .out_valid_o(ov), .out_ready_i(rdy),
    .out_data_o(od), .out_eol_o(oel), .out_eof_o(oef));
  fma_host_rx host (.clk_i(clk), .rst_n_i(rst_n), .stall_i(stall), .slow_i(slow),
    .valid_i(ov), .data_i(od), .eol_i(oel), .eof_i(oef), .ready_o(rdy));

  // Clock and cycle count since reset release, for the time base
  always #4 clk = !clk;
  always @(posedge clk)
    if (rst_n)
      cyc++;

  task automatic cmp_val(input string nm, input logic [31:0] ex, input logic [31:0] got);
    checks++;
    if (got !== ex)
    begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", nm, ex, got);
    end
  endtask : cmp_val

  // Live values; x flips them all so later changes must not reach the record
  task automatic set_live(input logic [31:0] x);
    hs = 16'h0012 ^ x[15:0];
    vs = 16'h0034 ^ x[15:0];
    ag = 16'h001E ^ x[15:0];
    dg = 16'h0100 ^ x[15:0];
    exd = 32'h1234 ^ x;
    lag = 32'h56 ^ x;
    cnt = 32'h0BADF00D ^ x;
    pre = 8'h03 ^ x[7:0];
    tst = 8'hFF ^ x[7:0];
    ser = {96'h0, 32'h31304E53 ^ x};
    lab = {96'h0, 32'h4C424C31 ^ x};
  endtask : set_live

  // One pixel, entered at a falling edge, held until taken
  task automatic send(input logic [7:0] d, input logic l, input logic f);
    pv = 1;
    pd = d;
    peol = l;
    peof = f;
    // Ready is read between edges, where it is settled
    while (pr !== 1'b1) @(negedge clk);
    @(posedge clk);
    sent++;
    @(negedge clk);
  endtask : send

  // Events, then changed live values, then n pixels in lines of four
  task automatic frame(input logic m, input logic f, input logic [31:0] e, input int n);
    @(negedge clk);
    lines = 4'hA;
    set_live(32'h0);
    repeat (8) @(negedge clk);
    md = m;
    fmt = f;
    enc = e;
    fs = 1;
    t0 = cyc;
    @(negedge clk);
    fs = 0;
    es = 1;
    @(negedge clk);
    es = 0;
    rs = 1;
    @(negedge clk);
    rs = 0;
    lines = 4'h5;
    set_live(32'hFFFFFFFF);
    for (int i = 0; i < n; i++)
      send(i[7:0], (i % 4) == 3, i == n - 1);
    pv = 0;
  endtask : frame

  task automatic wait_rx(input int n);
    for (int k = 0; k < 3000 && host.rxq.size() < n; k++)
      @(negedge clk);
    cmp_val("beats", n, host.rxq.size());
  endtask : wait_rx

  function automatic logic [31:0] le(input int o);
    return {host.rxq[o+11][7:0], host.rxq[o+10][7:0], host.rxq[o+9][7:0], host.rxq[o+8][7:0]};
  endfunction : le

  task automatic print_verdict;
    if (err_total == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : print_verdict

  // Hang guard, far beyond the few hundred cycles the tests need
  initial
  begin
    #200000;
    err_total++;
    print_verdict();
  end

  // Main sequence
  initial
  begin
    set_live(32'h0);
    repeat (16) @(posedge clk);
    @(negedge clk);
    rst_n = 1;
    md = 1;
    for (int i = 0; i < 16; i++)
    begin
      sel = i[3:0];
      repeat (2) @(negedge clk);
      cmp_val("item enable", {31'b0, i != 15}, {31'b0, en});
    end
    foreach (ecase[k])
    begin
      {md, fmt, sel} = ecase[k];
      repeat (2) @(negedge clk);
      cmp_val("item enable off", 32'h0, {31'b0, en});
    end
    slow = 1;
    frame(1, FMT_STANDARD, 32'h01080001, 8);
    wait_rx(148);
    cmp_val("image end", 32'h1, host.rxq[7][9:8]);
    cmp_val("record wrap", 32'h1, host.rxq[11][9:8]);
    cmp_val("record end", 32'h3, host.rxq[147][9:8]);
    cmp_val("id", REC_ID, le(0));
    cmp_val("size", 32'd140, le(4));
    cmp_val("avail", 32'hF0019D46, le(8));
    cmp_val("avail high", 32'h0, le(12));
    foreach (offs[i])
      cmp_val($sformatf("field %0d", offs[i]), exps[i], le(offs[i]));
    cmp_val("timestamp", 32'h1, {31'b0, (le(76) + 1 >= t0 / 125)
      && (le(76) <= t0 / 125 + 1)});
    slow = 0;
    // Off, other format, 16-bit: no record; host stalls to fill the FIFO
    for (int c = 0; c < 3; c++)
    begin
      host.rxq.delete();
      stall = 1;
      sent = 0;
      fork
        frame(c != 0, c == 1, (c == 2) ? 32'h01100003 : 32'h01080001, 12);
        begin
          repeat (60) @(negedge clk);
          cmp_val("taken while stalled", 32'd8, sent);
          stall = 0;
        end
      join
      wait_rx(12);
      cmp_val("plain end", 32'h3, host.rxq[11][9:8]);
      cmp_val("drained", 32'h0, {31'b0, ov});
    end
    print_verdict();
  end
endmodule : tb_top
